// >>> rtl/watchdog_mode_gate.sv
module watchdog_mode_gate
  import wdt_cfg_pkg::*;
(
  input  wire logic       loaded,
  input  wire logic [1:0] mode,
  input  wire logic       swon,
  input  wire logic       sleep_active,
  output logic            run
);

  always_comb begin
    case (wdt_mode_t'(mode))
      MODE_ALWAYS: run = loaded;
      MODE_AWAKE:  run = loaded & ~sleep_active;
      MODE_SW:     run = loaded & swon;
      MODE_OFF:    run = 1'b0;
      default:     run = 1'b0;
    endcase
  end

endmodule : watchdog_mode_gate

// >>> rtl/watchdog_window_decode.sv
module watchdog_window_decode
  import wdt_cfg_pkg::*;
(
  input  wire logic [WIN_W-1:0] code,
  output logic      [WIN_W-1:0] closed_eighths,
  output logic                  sw_ctrl
);

  always_comb begin
    // 111 and 110 fully open, then 25 % closed rising by 12.5 % per step
    if (code[2:1] == 2'b11) begin
      closed_eighths = 3'h0;
    end else begin
      closed_eighths = 3'h7 - code;
    end
    sw_ctrl = code[2];
  end

endmodule : watchdog_window_decode

// >>> rtl/wdt_cfg_pkg.sv
package wdt_cfg_pkg;

  localparam int CFG_W = 14;
  localparam int WIN_W = 3;
  localparam int IRQ_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_KEY        = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // configuration word layout
  localparam int CFG_MODE_LO    = 5;
  localparam int CFG_MODE_HI    = 6;
  localparam int CFG_UNIMPL_BIT = 7;
  localparam int CFG_WIN_LO     = 8;
  localparam int CFG_WIN_HI     = 10;
  localparam logic [CFG_W-1:0] CFG_UNIMPL_MASK = 14'h0080;
  localparam logic [CFG_W-1:0] CFG_RESET       = 14'h3FFF;

  // control register layout
  localparam int CTRL_SWON_BIT = 0;
  localparam int CTRL_WIN_LO   = 1;
  localparam int CTRL_WIN_HI   = 3;
  localparam logic [WIN_W-1:0] WIN_RT_RESET = 3'h7;
  localparam logic [31:0]      KEY_VALUE    = 32'h0000005A;

  // status register layout
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_CLOSED_LO  = 1;
  localparam int ST_CLOSED_HI  = 3;
  localparam int ST_SWCTRL_BIT = 4;

  // interrupt bits
  localparam int IRQ_RUN_START = 0;
  localparam int IRQ_RUN_STOP  = 1;
  localparam int IRQ_REFUSED   = 2;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SW     = 2'b01,
    MODE_AWAKE  = 2'b10,
    MODE_ALWAYS = 2'b11
  } wdt_mode_t;

  typedef struct packed {
    logic             run;
    logic [WIN_W-1:0] closed_eighths;
    logic             sw_ctrl;
  } wdt_view_t;

  typedef struct packed {
    logic             loaded;
    logic [CFG_W-1:0] cfg;
    logic             swon;
    logic [WIN_W-1:0] win_rt;
    logic             key_armed;
    wdt_view_t        view;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic             irq;
    logic             dp_valid;
    logic             dp_wr;
    logic [7:0]       dp_addr;
    logic [31:0]      rdata;
    logic             ready;
    logic             resp;
  } wdt_state_t;

endpackage : wdt_cfg_pkg

// >>> rtl/windowed_watchdog_config.sv
// Contract
// - mode 11: always runs, software enable ignored
// - mode 10: runs awake, suspended in sleep
// - mode 01: software enable alone starts, stops
// - mode 00: always disabled, enable ignored
// - window codes map to closed/open eighths
// - codes 1xx free window writes, else keyed
// - config bit 7 always reads one
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
module windowed_watchdog_config
  import wdt_cfg_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [CFG_W-1:0] nvm_word,
  input  wire logic             prog_load,
  input  wire logic             sleep_active,
  output wdt_view_t             wdt_view,
  output logic                  irq
);

  wdt_state_t       s_reg;
  wdt_state_t       s_next;
  logic             run_now;
  logic [WIN_W-1:0] closed_rt;
  logic             sw_ctrl_cfg;
  logic             refused;
  logic [WIN_W-1:0] new_win;
  logic [IRQ_W-1:0] events;

  function automatic logic [31:0] read_word(input wdt_state_t st, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      OFS_CONFIG: begin
        w[CFG_W-1:0] = st.cfg;
      end
      OFS_CONTROL: begin
        w[CTRL_SWON_BIT]            = st.swon;
        w[CTRL_WIN_HI:CTRL_WIN_LO]  = st.win_rt;
      end
      OFS_STATUS: begin
        w[ST_RUN_BIT]                = st.view.run;
        w[ST_CLOSED_HI:ST_CLOSED_LO] = st.view.closed_eighths;
        w[ST_SWCTRL_BIT]             = st.view.sw_ctrl;
      end
      OFS_IRQ_STATUS: begin
        w[IRQ_W-1:0] = st.irq_stat;
      end
      OFS_IRQ_ENABLE: begin
        w[IRQ_W-1:0] = st.irq_en;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction : read_word

  watchdog_mode_gate u_mode_gate (
    .loaded       (s_reg.loaded),
    .mode         (s_reg.cfg[CFG_MODE_HI:CFG_MODE_LO]),
    .swon         (s_reg.swon),
    .sleep_active (sleep_active),
    .run          (run_now)
  );

  watchdog_window_decode u_win_rt (
    .code           (s_reg.win_rt),
    .closed_eighths (closed_rt),
    .sw_ctrl        ()
  );

  watchdog_window_decode u_win_cfg (
    .code           (s_reg.cfg[CFG_WIN_HI:CFG_WIN_LO]),
    .closed_eighths (),
    .sw_ctrl        (sw_ctrl_cfg)
  );

  always_comb begin
    s_next   = s_reg;
    refused  = 1'b0;
    new_win  = hwdata[CTRL_WIN_HI:CTRL_WIN_LO];
    s_next.ready    = 1'b1;
    s_next.resp     = 1'b0;
    s_next.dp_valid = 1'b0;

    // config only comes from storage or the programming port
    if (!s_reg.loaded || prog_load) begin
      s_next.loaded = 1'b1;
      s_next.cfg    = nvm_word | CFG_UNIMPL_MASK;
      if (!s_reg.loaded) begin
        s_next.win_rt = nvm_word[CFG_WIN_HI:CFG_WIN_LO];
      end
    end

    // data phase of a write
    if (s_reg.dp_valid && s_reg.dp_wr) begin
      case (s_reg.dp_addr)
        OFS_CONTROL: begin
          s_next.swon      = hwdata[CTRL_SWON_BIT];
          s_next.key_armed = 1'b0;
          if (sw_ctrl_cfg || s_reg.key_armed) begin
            s_next.win_rt = new_win;
          end else if (new_win != s_reg.win_rt) begin
            refused = 1'b1;
          end
        end
        OFS_KEY: begin
          s_next.key_armed = (hwdata == KEY_VALUE);
        end
        OFS_IRQ_CLEAR: begin
          s_next.irq_stat = s_reg.irq_stat & ~hwdata[IRQ_W-1:0];
        end
        OFS_IRQ_ENABLE: begin
          s_next.irq_en = hwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    events                = '0;
    events[IRQ_RUN_START] = run_now & ~s_reg.view.run;
    events[IRQ_RUN_STOP]  = ~run_now & s_reg.view.run;
    events[IRQ_REFUSED]   = refused;
    // set after the clear so a same-cycle event survives
    s_next.irq_stat = s_next.irq_stat | events;
    s_next.irq      = |(s_reg.irq_stat & s_reg.irq_en);

    s_next.view.run            = run_now;
    s_next.view.closed_eighths = closed_rt;
    s_next.view.sw_ctrl        = sw_ctrl_cfg;

    // address phase; read data is sampled here, master idles between
    if (hsel && hready && htrans[1]) begin
      s_next.dp_valid = 1'b1;
      s_next.dp_wr    = hwrite;
      s_next.dp_addr  = haddr[7:0];
      s_next.rdata    = hwrite ? 32'h0 : read_word(s_reg, haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg        <= '0;
      s_reg.cfg    <= CFG_RESET;
      s_reg.win_rt <= WIN_RT_RESET;
      s_reg.ready  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata    = s_reg.rdata;
  assign hreadyout = s_reg.ready;
  assign hresp     = s_reg.resp;
  assign wdt_view  = s_reg.view;
  assign irq       = s_reg.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [1:0] mode_now;
  logic       ctrl_wr;
  assign mode_now = s_reg.cfg[CFG_MODE_HI:CFG_MODE_LO];
  assign ctrl_wr  = s_reg.dp_valid && s_reg.dp_wr && (s_reg.dp_addr == OFS_CONTROL);

  logic             rd_take;
  logic             clr_wr;
  logic [IRQ_W-1:0] clr_mask;
  assign rd_take  = hsel && hready && htrans[1] && !hwrite;
  assign clr_wr   = s_reg.dp_valid && s_reg.dp_wr && (s_reg.dp_addr == OFS_IRQ_CLEAR);
  assign clr_mask = clr_wr ? hwdata[IRQ_W-1:0] : '0;

  property p_mode_always;
    s_reg.loaded && (mode_now == 2'b11) && !prog_load |=> wdt_view.run;
  endproperty
  a_mode_always: assert property (p_mode_always) else $error("mode 11 did not run");

  property p_mode_awake;
    s_reg.loaded && (mode_now == 2'b10) && !prog_load |=> (wdt_view.run == !$past(sleep_active));
  endproperty
  a_mode_awake: assert property (p_mode_awake) else $error("mode 10 run not tied to sleep");

  property p_mode_sw;
    s_reg.loaded && (mode_now == 2'b01) && !prog_load |=> (wdt_view.run == $past(s_reg.swon));
  endproperty
  a_mode_sw: assert property (p_mode_sw) else $error("mode 01 run not tied to enable");

  property p_mode_off;
    (mode_now == 2'b00) && !prog_load |=> !wdt_view.run;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode 00 ran");

  property p_power_on_window;
    $rose(s_reg.loaded) |-> (s_reg.win_rt == s_reg.cfg[CFG_WIN_HI:CFG_WIN_LO]);
  endproperty
  a_power_on_window: assert property (p_power_on_window) else $error("power-on window wrong");

  property p_window_split;
    ##1 1'b1 |-> (wdt_view.closed_eighths ==
      (($past(s_reg.win_rt) >= 3'h6) ? 3'h0 : 3'h7 - $past(s_reg.win_rt)));
  endproperty
  a_window_split: assert property (p_window_split) else $error("closed fraction wrong");

  property p_keyed_refuse;
    ctrl_wr && !s_reg.cfg[CFG_WIN_HI] && !s_reg.key_armed && (new_win != s_reg.win_rt)
      |=> $stable(s_reg.win_rt) && s_reg.irq_stat[IRQ_REFUSED] ##1 irq == $past(s_reg.irq_en[IRQ_REFUSED]);
  endproperty
  a_keyed_refuse: assert property (p_keyed_refuse) else $error("locked window write accepted");

  property p_free_write;
    ctrl_wr && (s_reg.cfg[CFG_WIN_HI] || s_reg.key_armed) |=> (s_reg.win_rt == $past(new_win));
  endproperty
  a_free_write: assert property (p_free_write) else $error("allowed window write lost");

  property p_bit7_one;
    s_reg.loaded |-> s_reg.cfg[CFG_UNIMPL_BIT];
  endproperty
  a_bit7_one: assert property (p_bit7_one) else $error("config bit 7 not one");

  property p_cfg_locked;
    s_reg.loaded && !prog_load |=> $stable(s_reg.cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config changed without programming");

  // read path: the bus must see what the register holds
  property p_cfg_read_bit7;
    rd_take && (haddr[7:0] == OFS_CONFIG) |=> hrdata[CFG_UNIMPL_BIT];
  endproperty
  a_cfg_read_bit7: assert property (p_cfg_read_bit7) else $error("config read bit 7 not one");

  property p_cfg_read_word;
    rd_take && (haddr[7:0] == OFS_CONFIG) |=> (hrdata == {18'h0, $past(s_reg.cfg)});
  endproperty
  a_cfg_read_word: assert property (p_cfg_read_word) else $error("config read differs from word");

  property p_cfg_reload;
    s_reg.loaded && prog_load |=> (s_reg.cfg == ($past(nvm_word) | CFG_UNIMPL_MASK));
  endproperty
  a_cfg_reload: assert property (p_cfg_reload) else $error("programming reload lost");

  // reload keeps the runtime window so a locked setting is not bypassed
  property p_reload_keeps_window;
    s_reg.loaded && prog_load && !ctrl_wr |=> $stable(s_reg.win_rt);
  endproperty
  a_reload_keeps_window: assert property (p_reload_keeps_window) else $error("reload moved window");

  property p_status_read_run;
    rd_take && (haddr[7:0] == OFS_STATUS) |=> (hrdata[ST_RUN_BIT] == $past(wdt_view.run));
  endproperty
  a_status_read_run: assert property (p_status_read_run) else $error("status run bit wrong");

  // gated on loaded: the view lags the config by one edge after reset
  property p_sw_ctrl_view;
    s_reg.loaded |=> (wdt_view.sw_ctrl == $past(s_reg.cfg[CFG_WIN_HI]));
  endproperty
  a_sw_ctrl_view: assert property (p_sw_ctrl_view) else $error("software control flag wrong");

  property p_keyed_disarm;
    ctrl_wr |=> !s_reg.key_armed;
  endproperty
  a_keyed_disarm: assert property (p_keyed_disarm) else $error("key stayed armed");

  // flags are sticky; only a clear write drops them
  property p_refused_sticky;
    s_reg.irq_stat[IRQ_REFUSED] && !clr_mask[IRQ_REFUSED] |=> s_reg.irq_stat[IRQ_REFUSED];
  endproperty
  a_refused_sticky: assert property (p_refused_sticky) else $error("refused flag dropped");

  property p_refused_clear;
    clr_mask[IRQ_REFUSED] && !events[IRQ_REFUSED] |=> !s_reg.irq_stat[IRQ_REFUSED];
  endproperty
  a_refused_clear: assert property (p_refused_clear) else $error("refused flag not cleared");

  property p_run_start_flag;
    run_now && !wdt_view.run |=> s_reg.irq_stat[IRQ_RUN_START];
  endproperty
  a_run_start_flag: assert property (p_run_start_flag) else $error("run start not flagged");

  property p_run_stop_flag;
    !run_now && wdt_view.run |=> s_reg.irq_stat[IRQ_RUN_STOP];
  endproperty
  a_run_stop_flag: assert property (p_run_stop_flag) else $error("run stop not flagged");

  property p_irq_raise;
    s_reg.irq_stat[IRQ_REFUSED] && s_reg.irq_en[IRQ_REFUSED] |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled refused flag gave no interrupt");

  property p_irq_quiet;
    ((s_reg.irq_stat & s_reg.irq_en) == '0) |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled flag");

  c_run_start: cover property ($rose(wdt_view.run));
  c_refused:   cover property (ctrl_wr ##1 s_reg.irq_stat[IRQ_REFUSED]);
  c_keyed:     cover property (s_reg.key_armed && ctrl_wr && !s_reg.cfg[CFG_WIN_HI]);
  c_irq:       cover property ($rose(irq));
  c_sleep:     cover property ((mode_now == 2'b10) && sleep_active ##1 !wdt_view.run);

endmodule : windowed_watchdog_config

// >>> sim/testbench.sv
module testbench
  import wdt_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic             hready;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  logic [CFG_W-1:0] nvm_word;
  logic             prog_load;
  logic             sleep_active;
  wdt_view_t        wdt_view;
  logic             irq;
  int               fail_count;
  int               checks;
  logic [2:0]       cl;
  logic             run;

  assign hready = hreadyout;

  windowed_watchdog_config windowed_watchdog_config_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nvm_word(nvm_word), .prog_load(prog_load),
    .sleep_active(sleep_active), .wdt_view(wdt_view), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic complete_run();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // single word transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
    chk("hresp", 32'h00000000, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h00000000, d);
    chk(name, exp, d);
  endtask : rdc

  // programming port reload, then let the run flag settle
  task automatic load(input logic [CFG_W-1:0] v);
    @(posedge hclk);
    nvm_word  <= v;
    prog_load <= 1'b1;
    @(posedge hclk);
    prog_load <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : load

  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    complete_run();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    nvm_word = 14'h0560;
    prog_load = 1'b0;
    sleep_active = 1'b0;
    repeat (6) @(posedge hclk);
    chk("reset view", 32'h00000000, {27'h0, wdt_view});
    chk("reset irq", 32'h00000000, {31'h0, irq});
    chk("reset hrdata", 32'h00000000, hrdata);
    chk("reset hreadyout", 32'h00000001, {31'h0, hreadyout});
    chk("reset hresp", 32'h00000000, {31'h0, hresp});
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc("config", OFS_CONFIG, 32'h000005E0);
    wr(OFS_CONFIG, 32'h00000000);
    rdc("config kept", OFS_CONFIG, 32'h000005E0);
    rdc("status", OFS_STATUS, 32'h00000015);
    chk("view", 32'h00000015, {27'h0, wdt_view});
    // every mode against sleep and software enable
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        for (int w = 0; w < 2; w++) begin
          load(14'h0500 | 14'(m << 5));
          sleep_active <= s[0];
          wr(OFS_CONTROL, {28'h0, 3'h5, w[0]});
          run = (m == 3) || (m == 2 && s == 0) || (m == 1 && w == 1);
          rdc("status run", OFS_STATUS, {27'h0, 1'b1, 3'h2, run});
          chk("view run", {31'h0, run}, {31'h0, wdt_view.run});
        end
      end
    end
    sleep_active <= 1'b0;
    load(14'h0560);
    // all window codes with software control allowed
    for (int c = 0; c < 8; c++) begin
      cl = (c >= 6) ? 3'h0 : 3'(7 - c);
      wr(OFS_CONTROL, {28'h0, c[2:0], 1'b0});
      rdc("control", OFS_CONTROL, {28'h0, c[2:0], 1'b0});
      rdc("status window", OFS_STATUS, {27'h0, 1'b1, cl, 1'b1});
    end
    // locked window: refused write, then keyed write
    load(14'h0360);
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    wr(OFS_IRQ_ENABLE, 32'h00000004);
    rdc("irq clear", OFS_IRQ_STATUS, 32'h00000000);
    wr(OFS_CONTROL, 32'h00000000);
    rdc("locked control", OFS_CONTROL, 32'h0000000E);
    rdc("refused flag", OFS_IRQ_STATUS, 32'h00000004);
    chk("irq raised", 32'h00000001, {31'h0, irq});
    wr(OFS_KEY, KEY_VALUE);
    wr(OFS_CONTROL, 32'h00000000);
    rdc("keyed control", OFS_CONTROL, 32'h00000000);
    rdc("keyed status", OFS_STATUS, 32'h0000000F);
    wr(OFS_IRQ_CLEAR, 32'h00000004);
    rdc("flag cleared", OFS_IRQ_STATUS, 32'h00000000);
    chk("irq cleared", 32'h00000000, {31'h0, irq});
    wr(OFS_IRQ_ENABLE, 32'h00000000);
    wr(OFS_CONTROL, 32'h00000002);
    rdc("relocked control", OFS_CONTROL, 32'h00000000);
    rdc("masked flag", OFS_IRQ_STATUS, 32'h00000004);
    chk("irq masked", 32'h00000000, {31'h0, irq});
    rdc("config locked", OFS_CONFIG, 32'h000003E0);
    rdc("unmapped", 8'h1C, 32'h00000000);
    // wrong key leaves the window locked
    wr(OFS_KEY, 32'h0000005B);
    wr(OFS_CONTROL, 32'h00000004);
    rdc("wrong key control", OFS_CONTROL, 32'h00000000);
    // run stop and start events
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    load(14'h0300);
    rdc("stop flag", OFS_IRQ_STATUS, 32'h00000002);
    load(14'h0360);
    rdc("start flag", OFS_IRQ_STATUS, 32'h00000003);
    complete_run();
  end
endmodule : testbench
